// ==== core/sbfm_chan_filter.sv ====
// one safe-stop channel: three-stage synchroniser and short-off filter
`timescale 1ns/10ps
`default_nettype none
`include "sbfm_map.svh"
module sbfm_chan_filter #(
  parameter int unsigned GLITCH_CYC = `SBFM_GLITCH_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // raw pin, high means on
  input  wire logic pin_on,
  // filtered level, high means on
  output logic      filt_on
);
  // the counter compares against GLITCH_CYC - 1, so two cycles is the floor
  if (GLITCH_CYC < 2) begin : g_bad_glitch_cyc
    $error("GLITCH_CYC too small");
  end

  logic [2:0]  sync_q;
  logic [2:0]  sync_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        filt_q;
  logic        filt_d;
  // length of the current agreeing off run, read only by the check below
  logic [31:0] low_run_q;
  logic [31:0] low_run_d;

  always_comb begin
    sync_d = {sync_q[1:0], pin_on};
    low_run_d = low_run_q;
    if (sync_q[2] || sync_q[1]) begin
      low_run_d = 32'h0;
    end else if (low_run_q < GLITCH_CYC) begin
      low_run_d = low_run_q + 32'h1;
    end
    cnt_d  = cnt_q;
    filt_d = filt_q;
    if (sync_q[2] != sync_q[1]) begin
      cnt_d = 32'h0;
    end else if (sync_q[2] == filt_q) begin
      cnt_d = 32'h0;
    end else if (!sync_q[2]) begin
      // off must outlast the glitch window to count
      if (cnt_q >= GLITCH_CYC - 1) begin
        filt_d = 1'b0;
        cnt_d  = 32'h0;
      end else begin
        cnt_d = cnt_q + 32'h1;
      end
    end else begin
      filt_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_q <= 3'h7;
      cnt_q  <= 32'h0;
      filt_q <= 1'b1;
      low_run_q <= 32'h0;
    end else begin
      sync_q <= sync_d;
      cnt_q  <= cnt_d;
      filt_q <= filt_d;
      low_run_q <= low_run_d;
    end
  end

  assign filt_on = filt_q;

  property p_short_off_ignored;
    @(posedge clk) disable iff (rst)
      $fell(filt_q) |-> low_run_q == GLITCH_CYC;
  endproperty
  a_short_off_ignored: assert property (p_short_off_ignored) else $error("short off taken as stop");

  property p_sync_stages;
    @(posedge clk) disable iff (rst)
      (!filt_q && sync_q[1] && !sync_q[2]) ##1 sync_q[1] |=> filt_q;
  endproperty
  a_sync_stages: assert property (p_sync_stages) else $error("on level not followed");
endmodule : sbfm_chan_filter
`default_nettype wire

// ==== core/sbfm_map.svh ====
// timing and field constants for the safe-stop feedback monitor
`ifndef SBFM_MAP_SVH
`define SBFM_MAP_SVH
`define SBFM_CLK_HZ          40000000
`define SBFM_GLITCH_US       500
`define SBFM_GLITCH_CYC      ((`SBFM_CLK_HZ / 1000000) * `SBFM_GLITCH_US + 1)
`define SBFM_MISMATCH_S      10
`define SBFM_MISMATCH_CYC    (`SBFM_CLK_HZ * `SBFM_MISMATCH_S)
`define SBFM_FEEDBACK_MS     20
`define SBFM_FEEDBACK_CYC    ((`SBFM_CLK_HZ / 1000) * `SBFM_FEEDBACK_MS)
`define SBFM_MON_A_BIT       0
`define SBFM_MON_B_BIT       1
`define SBFM_MON_RESET       16'h0003
`define SBFM_DISP_NORMAL     8'h00
`define SBFM_DISP_BASEBLOCK  8'h01
`endif

// ==== core/sbfm_pkg.sv ====
// types for the safe-stop feedback monitor
`default_nettype none
package sbfm_pkg;
  typedef enum logic [1:0] {
    SBFM_OPERATE  = 2'b00,
    SBFM_BASEBLK  = 2'b01,
    SBFM_PARTIAL  = 2'b10
  } sbfm_state_type;

  typedef struct packed {
    logic chan_a_on;
    logic chan_b_on;
  } sbfm_chan_type;
endpackage : sbfm_pkg
`default_nettype wire

// ==== core/sbfm_top.sv ====
// safe-stop feedback monitor top
`timescale 1ns/10ps
`default_nettype none
`include "sbfm_map.svh"
module sbfm_top #(
  parameter int unsigned GLITCH_CYC   = `SBFM_GLITCH_CYC,
  parameter int unsigned MISMATCH_CYC = `SBFM_MISMATCH_CYC
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // safe-stop pins, high means on (current flowing)
  input  wire logic        SAFE_STOP_IN_A,
  input  wire logic        SAFE_STOP_IN_B,
  // feedback to the safety unit, high means both channels off
  output logic             SAFE_STOP_FEEDBACK_OUT,
  // status
  output logic [15:0]      SAFE_INPUT_MONITOR_WORD,
  output logic [7:0]       DISPLAY_CODE,
  output logic             MOTOR_INHIBIT,
  output logic             INPUT_MISMATCH_ALARM,
  // clears a latched mismatch alarm
  input  wire logic        ALARM_CLEAR
);
  if (MISMATCH_CYC < 2) begin : g_bad_mismatch_cyc
    $error("MISMATCH_CYC too small");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel filtering
  // a net, since each filter instance drives one member
  wire sbfm_pkg::sbfm_chan_type chan;

  sbfm_chan_filter #(.GLITCH_CYC(GLITCH_CYC)) u_chan_a (
    .clk     (CLK),
    .rst     (RST),
    .pin_on  (SAFE_STOP_IN_A),
    .filt_on (chan.chan_a_on)
  );

  sbfm_chan_filter #(.GLITCH_CYC(GLITCH_CYC)) u_chan_b (
    .clk     (CLK),
    .rst     (RST),
    .pin_on  (SAFE_STOP_IN_B),
    .filt_on (chan.chan_b_on)
  );

  // the alarm clear comes from outside the clock domain
  logic [2:0] clr_sync_q;
  logic [2:0] clr_sync_d;
  logic       clr_lvl_q;
  logic       clr_lvl_d;

  always_comb begin
    clr_sync_d = {clr_sync_q[1:0], ALARM_CLEAR};
    clr_lvl_d  = (clr_sync_q[2] == clr_sync_q[1]) ? clr_sync_q[2] : clr_lvl_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state and outputs
  sbfm_pkg::sbfm_state_type state_q;
  sbfm_pkg::sbfm_state_type state_d;
  logic [31:0] mis_cnt_q;
  logic [31:0] mis_cnt_d;
  logic        fb_q;
  logic        fb_d;
  logic [15:0] mon_q;
  logic [15:0] mon_d;
  logic [7:0]  disp_q;
  logic [7:0]  disp_d;
  logic        inh_q;
  logic        inh_d;
  logic        alarm_q;
  logic        alarm_d;
  logic        both_off;

  always_comb begin
    both_off  = !chan.chan_a_on && !chan.chan_b_on;
    mis_cnt_d = 32'h0;
    alarm_d   = alarm_q;
    unique case (state_q)
      sbfm_pkg::SBFM_OPERATE: begin
        if (both_off) begin
          state_d = sbfm_pkg::SBFM_BASEBLK;
        end else if (chan.chan_a_on != chan.chan_b_on) begin
          state_d = sbfm_pkg::SBFM_PARTIAL;
        end else begin
          state_d = sbfm_pkg::SBFM_OPERATE;
        end
      end
      sbfm_pkg::SBFM_BASEBLK: begin
        if (chan.chan_a_on && chan.chan_b_on) begin
          state_d = sbfm_pkg::SBFM_OPERATE;
        end else if (!both_off) begin
          state_d = sbfm_pkg::SBFM_PARTIAL;
        end else begin
          state_d = sbfm_pkg::SBFM_BASEBLK;
        end
      end
      sbfm_pkg::SBFM_PARTIAL: begin
        if (both_off) begin
          state_d = sbfm_pkg::SBFM_BASEBLK;
        end else if (chan.chan_a_on && chan.chan_b_on) begin
          state_d = sbfm_pkg::SBFM_OPERATE;
        end else begin
          state_d   = sbfm_pkg::SBFM_PARTIAL;
          mis_cnt_d = mis_cnt_q;
          // the other channel did not follow in time
          if (mis_cnt_q >= MISMATCH_CYC - 1) begin
            alarm_d = 1'b1;
          end else begin
            mis_cnt_d = mis_cnt_q + 32'h1;
          end
        end
      end
      default: begin
        state_d = sbfm_pkg::SBFM_BASEBLK;
      end
    endcase
    // a new timeout in the clear cycle wins over the clear
    if (clr_lvl_q && !(state_q == sbfm_pkg::SBFM_PARTIAL && mis_cnt_q >= MISMATCH_CYC - 1)) begin
      alarm_d = 1'b0;
    end
    fb_d   = both_off;
    mon_d  = 16'h0;
    mon_d[`SBFM_MON_A_BIT] = chan.chan_a_on;
    mon_d[`SBFM_MON_B_BIT] = chan.chan_b_on;
    // any off channel stops the drive, both off shows the baseblock code
    inh_d  = !(chan.chan_a_on && chan.chan_b_on);
    disp_d = both_off ? `SBFM_DISP_BASEBLOCK : `SBFM_DISP_NORMAL;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      clr_sync_q <= 3'h0;
      clr_lvl_q  <= 1'b0;
      state_q    <= sbfm_pkg::SBFM_OPERATE;
      mis_cnt_q  <= 32'h0;
      fb_q       <= 1'b0;
      mon_q      <= `SBFM_MON_RESET;
      disp_q     <= `SBFM_DISP_NORMAL;
      inh_q      <= 1'b0;
      alarm_q    <= 1'b0;
    end else begin
      clr_sync_q <= clr_sync_d;
      clr_lvl_q  <= clr_lvl_d;
      state_q    <= state_d;
      mis_cnt_q  <= mis_cnt_d;
      fb_q       <= fb_d;
      mon_q      <= mon_d;
      disp_q     <= disp_d;
      inh_q      <= inh_d;
      alarm_q    <= alarm_d;
    end
  end

  assign SAFE_STOP_FEEDBACK_OUT  = fb_q;
  assign SAFE_INPUT_MONITOR_WORD = mon_q;
  assign DISPLAY_CODE            = disp_q;
  assign MOTOR_INHIBIT           = inh_q;
  assign INPUT_MISMATCH_ALARM    = alarm_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  property p_fb_truth;
    @(posedge CLK) disable iff (RST)
      1'b1 |=> fb_q == $past(!chan.chan_a_on && !chan.chan_b_on);
  endproperty
  a_fb_truth: assert property (p_fb_truth) else $error("feedback truth table broken");

  property p_fb_latency;
    @(posedge CLK) disable iff (RST)
      $changed(chan) |-> ##[1:2] fb_q == (!chan.chan_a_on && !chan.chan_b_on);
  endproperty
  a_fb_latency: assert property (p_fb_latency) else $error("feedback late");

  property p_mon_bits;
    @(posedge CLK) disable iff (RST)
      ##1 mon_q[1:0] == $past({chan.chan_b_on, chan.chan_a_on}) && mon_q[15:2] == 14'h0;
  endproperty
  a_mon_bits: assert property (p_mon_bits) else $error("monitor word wrong");

  sequence s_both_off;
    !chan.chan_a_on && !chan.chan_b_on;
  endsequence
  property p_baseblock_view;
    @(posedge CLK) disable iff (RST)
      s_both_off ##1 1'b1 |-> disp_q == `SBFM_DISP_BASEBLOCK && inh_q && fb_q;
  endproperty
  a_baseblock_view: assert property (p_baseblock_view) else $error("baseblock not shown");

  property p_alarm_timeout;
    @(posedge CLK) disable iff (RST)
      state_q == sbfm_pkg::SBFM_PARTIAL && mis_cnt_q == MISMATCH_CYC - 1 && $stable(chan) |=> alarm_q;
  endproperty
  a_alarm_timeout: assert property (p_alarm_timeout) else $error("mismatch alarm missed");

  property p_no_early_alarm;
    @(posedge CLK) disable iff (RST)
      !alarm_q && (state_q != sbfm_pkg::SBFM_PARTIAL || mis_cnt_q < MISMATCH_CYC - 1) |=> !alarm_q;
  endproperty
  a_no_early_alarm: assert property (p_no_early_alarm) else $error("alarm raised early");
endmodule : sbfm_top
`default_nettype wire

// ==== tb/sbfm_top_tb.sv ====
// self-checking bench for the safe-stop feedback monitor
`timescale 1ns/10ps
`default_nettype none
module sbfm_top_tb;
  localparam int GC = 8;
  localparam int MC = 50;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        guard = 1'b0;
  logic        stuck = 1'b0;
  logic        direct = 1'b1;
  logic        tb_a = 1'b1;
  logic        tb_b = 1'b1;
  logic        clr = 1'b0;
  logic        ua, ub, fbf, fb, inh, alm;
  logic [15:0] mon;
  logic [7:0]  disp;
  int          error_cnt = 0;
  int          check_count = 0;
  wire logic   pin_a = direct ? tb_a : ua;
  wire logic   pin_b = direct ? tb_b : ub;

  always #12.5 clk = ~clk;

  sbfm_top #(.GLITCH_CYC(GC), .MISMATCH_CYC(MC)) i_sbfm_top (
    .CLK(clk), .RST(rst), .SAFE_STOP_IN_A(pin_a), .SAFE_STOP_IN_B(pin_b),
    .SAFE_STOP_FEEDBACK_OUT(fb), .SAFE_INPUT_MONITOR_WORD(mon), .DISPLAY_CODE(disp),
    .MOTOR_INHIBIT(inh), .INPUT_MISMATCH_ALARM(alm), .ALARM_CLEAR(clr));
  sbfm_unit_model i_sbfm_unit_model (
    .clk(clk), .rst(rst), .guard_open(guard), .stuck_a_on(stuck),
    .feedback(fb), .stop_a(ua), .stop_b(ub), .fb_fault(fbf));

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic pins(input logic a, input logic b);
    tb_a = a;
    tb_b = b;
  endtask : pins

  // bounded wait for the monitor word, then judge monitor, feedback, display and inhibit
  task automatic settle(input logic a, input logic b);
    int n;
    n = 0;
    while (mon !== {14'h0000, b, a} && n < 60) begin
      cyc(1);
      n++;
    end
    if (n == 60) begin
      chk("monitor wait", {14'h0000, b, a}, mon);
      results();
    end
    cyc(2);
    chk("monitor", {14'h0000, b, a}, mon);
    chk("feedback", {15'h0000, !a && !b}, {15'h0000, fb});
    chk("display", (!a && !b) ? 16'h0001 : 16'h0000, {8'h00, disp});
    chk("inhibit", {15'h0000, !a || !b}, {15'h0000, inh});
  endtask : settle

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    cyc(1);
    chk("alarm", 16'h0000, {15'h0000, alm});
    chk("power-up", 16'h0000, {15'h0000, fbf});
    settle(1'b1, 1'b1);
  endtask : t_reset

  task automatic t_table();
    logic [1:0] c;
    for (int i = 0; i < 3; i++) begin
      c = i[1:0];
      pins(c[0], c[1]);
      settle(c[0], c[1]);
      pins(1'b1, 1'b1);
      cyc(2);
      chk("sync delay", {14'h0000, c[1], c[0]}, mon);
      settle(1'b1, 1'b1);
    end
  endtask : t_table

  task automatic t_glitch();
    logic bad;
    bad = 1'b0;
    pins(1'b0, 1'b0);
    // longest off run that the filter must still ignore
    cyc(GC);
    pins(1'b1, 1'b1);
    repeat (20) begin
      if (mon !== 16'h0003 || fb !== 1'b0) bad = 1'b1;
      cyc(1);
    end
    chk("short off", 16'h0000, {15'h0000, bad});
  endtask : t_glitch

  task automatic t_alarm();
    int n;
    pins(1'b0, 1'b1);
    settle(1'b0, 1'b1);
    cyc(MC - 20);
    chk("alarm early", 16'h0000, {15'h0000, alm});
    n = 0;
    while (alm !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk("alarm", 16'h0001, {15'h0000, alm});
    if (n == 40) results();
    pins(1'b1, 1'b1);
    settle(1'b1, 1'b1);
    chk("alarm held", 16'h0001, {15'h0000, alm});
    clr = 1'b1;
    cyc(8);
    clr = 1'b0;
    cyc(2);
    chk("alarm clear", 16'h0000, {15'h0000, alm});
    // a timeout under a held clear still sets the alarm
    clr = 1'b1;
    pins(1'b0, 1'b1);
    settle(1'b0, 1'b1);
    n = 0;
    while (alm !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    chk("alarm over clear", 16'h0001, {15'h0000, alm});
    if (n == 60) results();
    pins(1'b1, 1'b1);
    settle(1'b1, 1'b1);
    chk("alarm cleared", 16'h0000, {15'h0000, alm});
    clr = 1'b0;
  endtask : t_alarm

  task automatic t_unit();
    direct = 1'b0;
    guard = 1'b1;
    settle(1'b0, 1'b0);
    guard = 1'b0;
    settle(1'b1, 1'b1);
    stuck = 1'b1;
    guard = 1'b1;
    settle(1'b1, 1'b0);
    guard = 1'b0;
    cyc(20);
    chk("unit held", 16'h0000, {15'h0000, pin_b});
    stuck = 1'b0;
    guard = 1'b1;
    settle(1'b0, 1'b0);
    guard = 1'b0;
    settle(1'b1, 1'b1);
  endtask : t_unit

  initial begin
    cyc(5);
    rst = 1'b0;
    t_reset();
    t_table();
    t_glitch();
    t_alarm();
    t_unit();
    results();
  end
endmodule : sbfm_top_tb
`default_nettype wire

// ==== tb/sbfm_unit_model.sv ====
// behavioural safety unit with guard switch
`timescale 1ns/10ps
`default_nettype none
module sbfm_unit_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // guard and injected stuck-on fault
  input  wire logic guard_open,
  input  wire logic stuck_a_on,
  // device feedback and stop lines
  input  wire logic feedback,
  output logic      stop_a,
  output logic      stop_b,
  output logic      fb_fault
);
  logic chk_q;
  // feedback sampled once after reset, and it gates turning the stop lines back on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_a   <= 1'b1;
      stop_b   <= 1'b1;
      chk_q    <= 1'b0;
      fb_fault <= 1'b0;
    end else begin
      chk_q <= 1'b1;
      if (!chk_q) fb_fault <= feedback;
      if (guard_open) begin
        stop_a <= 1'b0;
        stop_b <= 1'b0;
      end else if (feedback) begin
        stop_a <= 1'b1;
        stop_b <= 1'b1;
      end
      if (stuck_a_on) stop_a <= 1'b1;
    end
  end
endmodule : sbfm_unit_model
`default_nettype wire
